/* File: shared/eppc_pkg.sv */
// Package: offsets, field positions, reset values, timing and types of the EPP port core
package eppc_pkg;
   // Register offsets
   localparam logic [2:0] EPPC_OFF_STATUS = 3'h1;
   localparam logic [2:0] EPPC_OFF_CTRL = 3'h2;
   localparam logic [2:0] EPPC_OFF_ADDR = 3'h3;
   localparam logic [2:0] EPPC_OFF_DATA0 = 3'h4;
   localparam logic [2:0] EPPC_OFF_DATA3 = 3'h7;
   // Status field positions
   localparam int EPPC_ST_CYCLE_TIMEOUT_FLAG = 0;
   localparam int EPPC_ST_PAPER = 5;
   localparam int EPPC_ST_ACK = 6;
   localparam int EPPC_ST_READY = 7;
   // Control field positions
   localparam int EPPC_CT_HCLK = 0;
   localparam int EPPC_CT_LFEED = 1;
   localparam int EPPC_CT_INIT = 2;
   localparam int EPPC_CT_SEL = 3;
   localparam int EPPC_CT_IRQEN = 4;
   localparam int EPPC_CT_DIR = 5;
   localparam logic [5:0] EPPC_CTRL_RST = 6'h00;
   localparam logic [7:0] EPPC_BYTE_RST = 8'h00;
   // Watchdog: 10 us at 100 MHz, longest time rounds down
   localparam int EPPC_CLK_MHZ = 100;
   localparam int EPPC_WDOG_US = 10;
   localparam int EPPC_WDOG_CYC = EPPC_WDOG_US * EPPC_CLK_MHZ;
   localparam int EPPC_WDOG_W = 11;

   typedef enum logic [2:0] {
      EPPC_IDLE = 3'b000,
      EPPC_ARM = 3'b001,
      EPPC_STRB = 3'b010,
      EPPC_DONE = 3'b011,
      EPPC_ABORT = 3'b100
   } eppc_state_e;

   // Peripheral-side outputs
   typedef struct packed {
      logic data_phase_strobe_n;
      logic addr_phase_strobe_n;
      logic periph_dir_write_n;
      logic pad_dir_out;
      logic host_clk_n;
      logic line_feed_n;
      logic periph_init_out;
      logic irq;
   } eppc_pins_s;
endpackage : eppc_pkg

/* File: rtl/eppc_core.sv */
// EPP parallel port core: control, status and EPP address/data ports with cycle sequencer
`timescale 1ns/100ps
// Function
// - Status bit 5 reports paper-out level
// - Status bit 6 reports acknowledge level
// - Status bit 7 reports inverted busy
// - Control bits 0-5 reset; 6-7 zero
// - Control bits drive outputs, 0/1/3 inverted
// - Acknowledge rising edge raises enabled interrupt
// - Direction bit acts only in extended mode
// - Address port write runs EPP address write
// - Address port read captures bus at strobe end
// - Four data ports run EPP data cycles
// - Idle bus follows control register settings
// - EPP 1.9 watchdog: strobe to wait release
// - EPP 1.7 watchdog: strobe to strobe end
// - Host-clock bit forces write during cycle
// - EPP 1.9 holds IOCHRDY low until done
// - EPP 1.9 write waits wait-low, then strobes
// - EPP 1.9 wait release ends strobe, frees IOCHRDY
// - EPP 1.9 read floats bus in the same cycle as the strobe
// - EPP 1.9 read captures bus on wait release
// - EPP 1.7 holds IOCHRDY only while wait low
// - Writing 1 clears timeout flag
module eppc_core
   import eppc_pkg::*;
#(
   parameter int WDOG_CYC = EPPC_WDOG_CYC
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Mode straps
   input wire logic i_epp_mode,
   input wire logic i_epp17_mode,
   input wire logic i_cfg_ext_mode_bit,
   // Host side
   input wire logic [2:0] i_addr,
   input wire logic i_ior_n,
   input wire logic i_iow_n,
   input wire logic [7:0] i_host_bus,
   output logic [7:0] o_host_bus,
   output logic o_host_bus_oe,
   output logic o_iochrdy,
   // Peripheral side
   input wire logic [7:0] i_pdata,
   output logic [7:0] o_pdata,
   output logic o_pdata_oe,
   input wire logic i_paper_out_in,
   input wire logic i_ack_n,
   input wire logic i_periph_ready_in,
   input wire logic i_periph_hold_n,
   output logic o_select_in_ctl_n,
   output eppc_pins_s o_pins
);

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   logic [5:0] sync1, sync2;
   logic ior_act, iow_act, hold_n, ack_s, ack_d, paper_s, ready_s;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1 <= 6'h3f;
         sync2 <= 6'h3f;
         ack_d <= 1'b1;
      end else begin
         sync1 <= {i_ior_n, i_iow_n, i_periph_hold_n, i_ack_n, i_paper_out_in,
                   i_periph_ready_in};
         sync2 <= sync1;
         ack_d <= ack_s;
      end
   end
   assign ior_act = !sync2[5];
   assign iow_act = !sync2[4];
   assign hold_n = sync2[3];
   assign ack_s = sync2[2];
   assign paper_s = sync2[1];
   assign ready_s = sync2[0];

   // ------------------------------------------------------------
   // Registers and sequencer
   // ------------------------------------------------------------
   eppc_state_e state, next_state;
   logic [5:0] ctrl, next_ctrl;
   logic [7:0] wbyte, next_wbyte, rbyte, next_rbyte;
   logic cycle_timeout_flag, next_cycle_timeout_flag, irq, next_irq, is_rd, next_is_rd, is_adr, next_is_adr;
   logic [EPPC_WDOG_W-1:0] wdog, next_wdog;
   logic [7:0] obus, next_obus;
   logic [7:0] stat;
   logic ior_d, iow_d, epp_sel, wdog_exp, strobing, ext_in, cyc;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ior_d <= 1'b0;
         iow_d <= 1'b0;
      end else begin
         ior_d <= ior_act;
         iow_d <= iow_act;
      end
   end

   assign epp_sel = i_epp_mode && (i_addr >= EPPC_OFF_ADDR);
   assign wdog_exp = (32'(wdog) >= WDOG_CYC);
   assign stat = {!ready_s, ack_s, paper_s, 4'h0, cycle_timeout_flag};

   always_comb begin
      next_state = state;
      next_ctrl = ctrl;
      next_wbyte = wbyte;
      next_rbyte = rbyte;
      next_cycle_timeout_flag = cycle_timeout_flag;
      next_is_rd = is_rd;
      next_is_adr = is_adr;
      next_wdog = wdog;
      next_obus = obus;
      next_irq = ctrl[EPPC_CT_IRQEN] && (irq || (ack_s && !ack_d));
      if (state != EPPC_IDLE && !wdog_exp) begin
         next_wdog = wdog + 1'b1;
      end
      // Plain register writes take the byte on the strobe's trailing edge
      if (!iow_act && iow_d) begin
         if (i_addr == EPPC_OFF_CTRL) begin
            next_ctrl = i_host_bus[5:0];
         end else if (i_addr == EPPC_OFF_STATUS && i_host_bus[EPPC_ST_CYCLE_TIMEOUT_FLAG]) begin
            next_cycle_timeout_flag = 1'b0;
         end
      end
      if (ior_act && !ior_d) begin
         if (i_addr == EPPC_OFF_STATUS) begin
            next_obus = stat;
         end else if (i_addr == EPPC_OFF_CTRL) begin
            next_obus = {2'b00, ctrl};
         end else if (!epp_sel) begin
            next_obus = EPPC_BYTE_RST;
         end
      end
      case (state)
         EPPC_IDLE: begin
            next_wdog = '0;
            if (epp_sel && ((ior_act && !ior_d) || (iow_act && !iow_d))) begin
               next_is_rd = ior_act;
               next_is_adr = (i_addr == EPPC_OFF_ADDR);
               next_wbyte = i_host_bus;
               next_state = i_epp17_mode ? EPPC_STRB : EPPC_ARM;
            end
         end
         EPPC_ARM: begin
            if (!hold_n) begin
               next_state = EPPC_STRB;
            end
         end
         EPPC_STRB: begin
            if (!is_rd) begin
               next_wbyte = i_host_bus;
            end
            if (i_epp17_mode) begin
               if (!(ior_act || iow_act)) begin
                  if (is_rd) begin
                     next_rbyte = i_pdata;
                  end
                  next_state = EPPC_IDLE;
               end
            end else if (hold_n) begin
               if (is_rd) begin
                  next_rbyte = i_pdata;
                  next_obus = i_pdata;
               end
               next_state = EPPC_DONE;
            end
         end
         EPPC_DONE, EPPC_ABORT: begin
            if (!(ior_act || iow_act)) begin
               next_state = EPPC_IDLE;
            end
         end
         default: next_state = EPPC_IDLE;
      endcase
      if (state == EPPC_STRB && i_epp17_mode && is_rd) begin
         next_obus = i_pdata;
      end
      if (state == EPPC_IDLE && epp_sel && ior_act && !ior_d) begin
         next_obus = rbyte;
      end
      // A timeout set wins over a simultaneous clear
      if ((state == EPPC_ARM || state == EPPC_STRB) && wdog_exp) begin
         next_cycle_timeout_flag = 1'b1;
         next_state = EPPC_ABORT;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= EPPC_IDLE;
         ctrl <= EPPC_CTRL_RST;
         wbyte <= EPPC_BYTE_RST;
         rbyte <= EPPC_BYTE_RST;
         cycle_timeout_flag <= 1'b0;
         irq <= 1'b0;
         is_rd <= 1'b0;
         is_adr <= 1'b0;
         wdog <= '0;
         obus <= EPPC_BYTE_RST;
      end else begin
         state <= next_state;
         ctrl <= next_ctrl;
         wbyte <= next_wbyte;
         rbyte <= next_rbyte;
         cycle_timeout_flag <= next_cycle_timeout_flag;
         irq <= next_irq;
         is_rd <= next_is_rd;
         is_adr <= next_is_adr;
         wdog <= next_wdog;
         obus <= next_obus;
      end
   end

   // ------------------------------------------------------------
   // Output registers
   // ------------------------------------------------------------
   assign strobing = (state == EPPC_STRB);
   // Pins keep their idle values until the sequencer reaches the strobe state
   assign cyc = (state == EPPC_STRB || state == EPPC_DONE);
   // Direction bit counts only outside printer mode
   assign ext_in = !i_cfg_ext_mode_bit && ctrl[EPPC_CT_DIR];
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_pins <= '{default: 1'b1};
         o_pdata <= EPPC_BYTE_RST;
         o_pdata_oe <= 1'b0;
         o_host_bus <= EPPC_BYTE_RST;
         o_host_bus_oe <= 1'b0;
         o_iochrdy <= 1'b1;
         o_select_in_ctl_n <= 1'b1;
      end else begin
         o_pins.host_clk_n <= !ctrl[EPPC_CT_HCLK];
         o_pins.line_feed_n <= !ctrl[EPPC_CT_LFEED];
         o_pins.periph_init_out <= ctrl[EPPC_CT_INIT];
         o_pins.irq <= irq;
         o_select_in_ctl_n <= !ctrl[EPPC_CT_SEL];
         o_pins.data_phase_strobe_n <= !(strobing && !is_adr);
         o_pins.addr_phase_strobe_n <= !(strobing && is_adr);
         if (cyc && state != EPPC_ABORT) begin
            // Host-clock bit overrides the read direction; a set direction bit turns
            // a write into a read with no error, as 1.9 software is told to avoid
            o_pins.periph_dir_write_n <= !(ctrl[EPPC_CT_HCLK] || (!is_rd && !ext_in));
            o_pdata_oe <= ctrl[EPPC_CT_HCLK] || (!is_rd && !ext_in);
            o_pins.pad_dir_out <= !(ctrl[EPPC_CT_HCLK] || (!is_rd && !ext_in));
            o_pdata <= wbyte;
         end else begin
            o_pins.periph_dir_write_n <= !ctrl[EPPC_CT_HCLK];
            o_pdata_oe <= !ext_in;
            o_pins.pad_dir_out <= ext_in;
            o_pdata <= wbyte;
         end
         o_host_bus <= next_obus;
         o_host_bus_oe <= ior_act && (i_addr != 3'h0) && (i_epp_mode || !epp_sel);
         if (i_epp17_mode) begin
            o_iochrdy <= !((state == EPPC_STRB) && !hold_n);
         end else begin
            o_iochrdy <= !(state == EPPC_ARM || state == EPPC_STRB ||
                           (state == EPPC_IDLE && next_state == EPPC_ARM));
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence strobe_live;
      state == EPPC_STRB;
   endsequence
   sequence wait_seen;
      hold_n && !i_epp17_mode;
   endsequence
   cycle_timeout_flag_sets_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ((state == EPPC_ARM || state == EPPC_STRB) && wdog_exp) |=> cycle_timeout_flag)
      else $error("timeout flag not set");
   cycle_timeout_flag_clr_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!iow_act && iow_d && i_addr == EPPC_OFF_STATUS && i_host_bus[0] && cycle_timeout_flag &&
       state == EPPC_IDLE) |=> !cycle_timeout_flag)
      else $error("timeout flag not cleared");
   end_strobe_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (strobe_live ##0 wait_seen ##0 !wdog_exp) |=> ##1 o_pins.data_phase_strobe_n &&
      o_pins.addr_phase_strobe_n)
      else $error("strobe not ended after wait release");
   rdy_low_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == EPPC_ARM && !i_epp17_mode) |=> !o_iochrdy)
      else $error("IOCHRDY not held");
   ctrl_top_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ior_act && !ior_d && i_addr == EPPC_OFF_CTRL) |=> o_host_bus[7:6] == 2'b00)
      else $error("control top bits not zero");
   irq_en_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      !ctrl[EPPC_CT_IRQEN] |=> !irq)
      else $error("interrupt while disabled");
   hclk_force_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      ctrl[EPPC_CT_HCLK] |=> !o_pins.periph_dir_write_n)
      else $error("host clock did not force write");
   wait_arm_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (state == EPPC_ARM && hold_n) |=> state != EPPC_STRB)
      else $error("strobe before wait low");
   stat_ready_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (ior_act && !ior_d && i_addr == EPPC_OFF_STATUS) |=>
      o_host_bus[EPPC_ST_READY] == !$past(i_periph_ready_in, 3))
      else $error("ready bit not inverted");
endmodule : eppc_core

/* File: sim/eppc_periph_model.sv */
// EPP peripheral model: answers each strobe after a set delay
`timescale 1ns/100ps
module eppc_periph_model
   import eppc_pkg::*;
(
   // Clock and pins from the core
   input wire logic i_clk,
   input wire eppc_pins_s i_pins,
   input wire logic [7:0] i_bus,
   // Test controls
   input wire logic [3:0] i_delay,
   input wire logic i_stall,
   input wire logic [7:0] i_rd_byte,
   // Peripheral outputs and capture
   output logic o_hold_n,
   output logic o_drive,
   output logic [7:0] o_data,
   output logic [7:0] o_got,
   output logic o_got_addr
);
   logic [3:0] cnt;
   logic strb;
   assign strb = !(i_pins.data_phase_strobe_n && i_pins.addr_phase_strobe_n);
   initial begin
      o_hold_n = 1'b0;
      o_drive = 1'b0;
      cnt = 4'h0;
   end
   // ----------------------------------------
   // Handshake: a stall holds wait low so the watchdog must fire
   // ----------------------------------------
   always @(posedge i_clk) begin
      if (!strb) begin
         cnt <= 4'h0;
         o_hold_n <= 1'b0;
         o_drive <= 1'b0;
      end else if (cnt != i_delay) begin
         cnt <= cnt + 4'h1;
         o_drive <= i_pins.periph_dir_write_n;
         o_data <= i_rd_byte;
      end else if (!i_stall && !o_hold_n) begin
         o_hold_n <= 1'b1;
         o_got <= i_bus;
         o_got_addr <= !i_pins.addr_phase_strobe_n;
      end
   end
endmodule : eppc_periph_model

/* File: sim/tb_top.sv */
// Testbench: register and EPP cycle tests of the port core
`timescale 1ns/100ps
module tb_top;
   import eppc_pkg::*;
   logic clk, rst_n, epp, e17, ext, ior_n, iow_n, paper, ack_n, rdy, sel_n;
   logic oe, drv, hold_n, got_a, stall, rdy_o, hoe, roe;
   logic [2:0] addr;
   logic [7:0] hbus, hq, rq, pbus, pq, last, rdb, mdat, got;
   logic [3:0] dly;
   eppc_pins_s pins;
   int err_count, n_compared;
   // Released bus flips every cycle so stale data cannot pass
   assign pbus = oe ? pq : (drv ? mdat : ~last);
   always @(posedge clk) last <= pbus;
   eppc_core #(.WDOG_CYC(20)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_epp_mode(epp),
      .i_epp17_mode(e17), .i_cfg_ext_mode_bit(ext), .i_addr(addr), .i_ior_n(ior_n),
      .i_iow_n(iow_n), .i_host_bus(hbus), .o_host_bus(hq), .o_host_bus_oe(hoe),
      .o_iochrdy(rdy_o), .i_pdata(pbus), .o_pdata(pq), .o_pdata_oe(oe),
      .i_paper_out_in(paper), .i_ack_n(ack_n), .i_periph_ready_in(rdy),
      .i_periph_hold_n(hold_n), .o_select_in_ctl_n(sel_n), .o_pins(pins));
   eppc_periph_model peri (.i_clk(clk), .i_pins(pins), .i_bus(pbus), .i_delay(dly),
      .i_stall(stall), .i_rd_byte(rdb), .o_hold_n(hold_n), .o_drive(drv),
      .o_data(mdat), .o_got(got), .o_got_addr(got_a));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic end_of_test;
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   // ----------------------------------------
   // Host access: strobe held until ready is seen high
   // ----------------------------------------
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr <= a;
      hbus <= d;
      iow_n <= !w;
      ior_n <= w;
      repeat (6) @(posedge clk);
      while (rdy_o !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      // Answer is taken at the edge that sees ready high, before the core moves on
      rq = hq;
      roe = hoe;
      if (n >= 400) begin
         err_count++;
         $display("CHECK FAILED at %0t: ready never returned", $time);
      end
      iow_n <= 1'b1;
      ior_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : acc
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      acc(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      cmp(rq, e);
      cmp({7'h00, roe}, 8'h01);
   endtask : rd
   task automatic pin_chk(input logic [7:0] e);
      repeat (5) @(posedge clk);
      cmp({pins.host_clk_n, pins.line_feed_n, pins.periph_init_out, sel_n,
         pins.pad_dir_out, pins.periph_dir_write_n, oe, pins.irq}, e);
   endtask : pin_chk
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      end_of_test();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {rst_n, e17, ext, stall, addr, hbus} = '0;
      {epp, ior_n, iow_n, paper, ack_n} = 5'b1_1110;
      {rdy, dly, rdb} = '0;
      dly = 4'h3;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      rd(EPPC_OFF_CTRL, 8'h00);
      rd(EPPC_OFF_STATUS, 8'ha0);
      @(posedge clk);
      {paper, ack_n, rdy} <= 3'b011;
      rd(EPPC_OFF_STATUS, 8'h40);
      wr(EPPC_OFF_CTRL, 8'hff);
      rd(EPPC_OFF_CTRL, 8'h3f);
      pin_chk(8'h28);
      ack_n <= 1'b0;
      repeat (4) @(posedge clk);
      ack_n <= 1'b1;
      pin_chk(8'h29);
      ext <= 1'b1;
      pin_chk(8'h23);
      ext <= 1'b0;
      wr(EPPC_OFF_CTRL, 8'h04);
      pin_chk(8'hf6);
      for (int i = 3; i < 8; i++) begin
         wr(3'(i), 8'h50 + 8'(i));
         cmp(got, 8'h50 + 8'(i));
         cmp({7'h0, got_a}, {7'h0, i == 3});
         rdb <= 8'ha0 + 8'(i);
         rd(3'(i), 8'ha0 + 8'(i));
      end
      for (int m = 0; m < 2; m++) begin
         e17 <= m[0];
         stall <= 1'b1;
         wr(EPPC_OFF_DATA0, 8'h11);
         stall <= 1'b0;
         rd(EPPC_OFF_STATUS, 8'h41);
         wr(EPPC_OFF_STATUS, 8'h00);
         rd(EPPC_OFF_STATUS, 8'h41);
         wr(EPPC_OFF_STATUS, 8'h01);
         rd(EPPC_OFF_STATUS, 8'h40);
      end
      wr(EPPC_OFF_DATA3, 8'h3c);
      cmp(got, 8'h3c);
      wr(EPPC_OFF_CTRL, 8'h20);
      rdb <= 8'hc3;
      rd(EPPC_OFF_ADDR, 8'hc3);
      epp <= 1'b0;
      rd(EPPC_OFF_DATA0, 8'h00);
      end_of_test();
   end
endmodule : tb_top
